// [core/pm_pkg.sv]
// Constants and types shared by the power mode clock scaler.
// Assumes one free-running base clock from which both derived clocks are cut.
// Notes on behaviour
// - Three modes exist: normal, reduced power and power off.
// - Normal pipeline clock is a pin-selected integer multiple of the reference.
// - Normal interface clock is half the pipeline clock or equals the reference.
// - Reduced power pipeline clock runs at a quarter of its normal rate.
// - Reduced power interface clock also runs at a quarter of normal rate.
// - Outside power off, writing the reduced power bit one cuts both clocks by four; zero restores.
// - Interface idled by an uncached read; write buffer empty when it completes.
// - All restart state is readable and writable by software.
// - Link reservation flag is cleared by invalidation at power-up.
// - Maintenance operations can invalidate every cache and TLB location.
package pm_pkg;

    localparam int unsigned HW = 8;
    typedef logic [HW-1:0] half_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_REDUCED,
        MODE_OFF
    } mode_t;

    // Reference half period in base clock cycles
    localparam half_t HALF_REF = 8'h0c;

    // Pipeline half period for each ratio select code (x1, x2, x3, x4)
    localparam half_t PIPE_HALF_TAB [4] = '{8'h0c, 8'h06, 8'h04, 8'h03};

    // Factor of four applied as a left shift of the half period
    localparam int unsigned RP_SHIFT = 2;

    localparam logic  RP_RST     = 1'b0;
    localparam logic  LL_RST     = 1'b0;
    localparam mode_t MODE_RST   = MODE_NORMAL;
    localparam logic  IFREF_RST  = 1'b0;
    localparam logic [1:0] SEL_RST = 2'h0;

    // Entries swept by one invalidate-all operation
    localparam int unsigned INV_ENTRIES = 64;
    localparam int unsigned INV_W       = $clog2(INV_ENTRIES);

endpackage

// [core/clk_div.sv]
// Glitch-free clock divider with run/stop control.
// Assumes i_half is at least one and may change at any time.
`timescale 1ns/1ps
module clk_div #(
    parameter int unsigned W = 8
) (
    input  wire logic         i_clock, // Base clock
    input  wire logic         i_rst,   // Async reset, active high
    input  wire logic [W-1:0] i_half,  // Requested half period
    input  wire logic         i_run,   // Low parks clock low
    output logic              o_clk    // Divided clock
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] half_ff;
    logic [W-1:0] len_ff;
    logic         clk_ff;
    logic         wrap;

    assign wrap  = (cnt_ff >= half_ff);
    assign o_clk = clk_ff;

    // Period latched at rise
    // New half period only taken at a rising edge, so both phases stay whole.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff  <= W'(1);
            half_ff <= W'(1);
            clk_ff  <= 1'b0;
        end else if (wrap) begin
            if (clk_ff) begin
                clk_ff <= 1'b0;
                cnt_ff <= W'(1);
            end else if (i_run) begin
                clk_ff  <= 1'b1;
                cnt_ff  <= W'(1);
                half_ff <= (i_half == '0) ? W'(1) : i_half;
            end
        end else begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    // Phase length, read only by the checks
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            len_ff <= W'(1);
        end else if (wrap && (clk_ff || i_run)) begin
            len_ff <= W'(1);
        end else if (len_ff != '1) begin
            len_ff <= len_ff + W'(1);
        end
    end

    a_no_runt_high: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (wrap && clk_ff) |-> (len_ff == half_ff))
        else $error("high phase length differs from latched half period");

    c_rise: cover property (@(posedge i_clock) disable iff (i_rst) $rose(clk_ff));

endmodule

// [core/power_mode_clock_scaler.sv]
// Power mode control and derived pipeline/interface clock generation.
// Assumes pins arrive asynchronously and control strobes come from logic on i_clock.
`timescale 1ns/1ps
module power_mode_clock_scaler #(
    parameter int unsigned ENTRIES = pm_pkg::INV_ENTRIES
) (
    input  wire logic                    i_clock,                // Base clock
    input  wire logic                    i_rst,                  // Async reset, active high
    input  wire logic [1:0]              i_clock_ratio_select,   // Ratio pins, async
    input  wire logic                    i_iface_at_ref,         // Interface clock = reference
    input  wire logic                    i_rp_wr,                // Reduced power bit write
    input  wire logic                    i_rp_wdata,             // Value written
    output logic                         o_reduced_power_select, // Bit readback
    input  wire logic                    i_power_down_req,       // Enter power off
    input  wire logic                    i_power_up_req,         // Leave power off
    output pm_pkg::mode_t                o_mode,                 // Current mode
    input  wire logic                    i_uncached_read_req,    // Uncached read issued
    input  wire logic                    i_wbuf_empty,           // Write buffer drained
    output logic                         o_uncached_read_done,   // Read completion pulse
    input  wire logic                    i_ll_set,               // Load-link sets flag
    input  wire logic                    i_ll_wr,                // Software flag write
    input  wire logic                    i_ll_wdata,             // Flag write value
    output logic                         o_link_reservation_flag, // Flag readback
    input  wire logic                    i_inv_all_start,        // Start invalidate-all
    output logic                         o_inv_busy,             // Sweep running
    output logic                         o_inv_valid,            // Index valid this cycle
    output logic [$clog2(ENTRIES)-1:0]   o_inv_index,            // Entry to invalidate
    output logic                         o_pipeline_clock,       // Derived pipeline clock
    output logic                         o_interface_clock       // Derived interface clock
);
    import pm_pkg::*;

    localparam int unsigned IW = $clog2(ENTRIES);
    localparam logic [IW-1:0] INV_LAST = IW'(ENTRIES - 1);

    // Pin synchronisers
    logic [1:0]  sel_s1_ff;
    logic [1:0]  sel_s2_ff;
    logic [1:0]  sel_s3_ff;
    logic [1:0]  sel_ff;
    logic        ifr_s1_ff;
    logic        ifr_s2_ff;
    logic        ifr_s3_ff;
    logic        ifr_ff;

    // Mode state
    mode_t       mode_ff;
    logic        rp_ff;

    // Clock period selection
    half_t       pipe_norm;
    half_t       iface_norm;
    half_t       pipe_half;
    half_t       iface_half;
    logic        run;

    // Interface idle handshake
    logic        read_pend_ff;
    logic        read_done_ff;

    // Reservation flag and sweep
    logic        ll_ff;
    logic        inv_busy_ff;
    logic [IW-1:0] inv_idx_ff;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_s1_ff <= SEL_RST;
            sel_s2_ff <= SEL_RST;
            sel_s3_ff <= SEL_RST;
            ifr_s1_ff <= IFREF_RST;
            ifr_s2_ff <= IFREF_RST;
            ifr_s3_ff <= IFREF_RST;
        end else begin
            sel_s1_ff <= i_clock_ratio_select;
            sel_s2_ff <= sel_s1_ff;
            sel_s3_ff <= sel_s2_ff;
            ifr_s1_ff <= i_iface_at_ref;
            ifr_s2_ff <= ifr_s1_ff;
            ifr_s3_ff <= ifr_s2_ff;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sel_ff <= SEL_RST;
            ifr_ff <= IFREF_RST;
        end else begin
            if (sel_s2_ff == sel_s3_ff) begin
                sel_ff <= sel_s3_ff;
            end
            if (ifr_s2_ff == ifr_s3_ff) begin
                ifr_ff <= ifr_s3_ff;
            end
        end
    end

    // External mode requests
    // Power down outranks power up, which outranks a reduced power write.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mode_ff <= MODE_RST;
        end else if (i_power_down_req) begin
            mode_ff <= MODE_OFF;
        end else if (mode_ff == MODE_OFF) begin
            if (i_power_up_req) begin
                mode_ff <= MODE_NORMAL;
            end
        end else if (i_rp_wr) begin
            mode_ff <= i_rp_wdata ? MODE_REDUCED : MODE_NORMAL;
        end
    end

    // Bit readable and writable
    // Writes are taken in any mode, but one made earlier in power off is cleared at power up.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rp_ff <= RP_RST;
        end else if (i_rp_wr) begin
            rp_ff <= i_rp_wdata;
        end else if (mode_ff == MODE_OFF && i_power_up_req && !i_power_down_req) begin
            rp_ff <= RP_RST;
        end
    end

    assign o_reduced_power_select = rp_ff;
    assign o_mode                 = mode_ff;

    assign pipe_norm = PIPE_HALF_TAB[sel_ff];

    assign iface_norm = ifr_ff ? HALF_REF : {pipe_norm[HW-2:0], 1'b0};

    always_comb begin
        pipe_half  = pipe_norm;
        iface_half = iface_norm;
        if (mode_ff == MODE_REDUCED) begin
            pipe_half  = {pipe_norm[HW-1-RP_SHIFT:0], {RP_SHIFT{1'b0}}};
            iface_half = {iface_norm[HW-1-RP_SHIFT:0], {RP_SHIFT{1'b0}}};
        end
    end

    assign run = (mode_ff != MODE_OFF);

    clk_div #(
        .W (HW)
    ) u_pipe_div (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_half  (pipe_half),
        .i_run   (run),
        .o_clk   (o_pipeline_clock)
    );

    clk_div #(
        .W (HW)
    ) u_iface_div (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_half  (iface_half),
        .i_run   (run),
        .o_clk   (o_interface_clock)
    );

    // Read held until drained
    // Completion is withheld while stores remain, so the system sees an idle bus.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            read_pend_ff <= 1'b0;
            read_done_ff <= 1'b0;
        end else begin
            read_done_ff <= read_pend_ff && i_wbuf_empty;
            if (i_uncached_read_req) begin
                read_pend_ff <= 1'b1;
            end else if (read_pend_ff && i_wbuf_empty) begin
                read_pend_ff <= 1'b0;
            end
        end
    end

    assign o_uncached_read_done = read_done_ff;

    // Invalidation clears flag
    // A load-link in the same cycle wins over the clear.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ll_ff <= LL_RST;
        end else if (i_ll_set) begin
            ll_ff <= 1'b1;
        end else if (i_inv_all_start) begin
            ll_ff <= 1'b0;
        end else if (i_ll_wr) begin
            ll_ff <= i_ll_wdata;
        end
    end

    assign o_link_reservation_flag = ll_ff;

    // Sweep every entry
    // A start during a sweep is ignored; the running sweep already covers all.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            inv_busy_ff <= 1'b0;
            inv_idx_ff  <= '0;
        end else if (!inv_busy_ff) begin
            if (i_inv_all_start) begin
                inv_busy_ff <= 1'b1;
                inv_idx_ff  <= '0;
            end
        end else if (inv_idx_ff == INV_LAST) begin
            inv_busy_ff <= 1'b0;
        end else begin
            inv_idx_ff <= inv_idx_ff + IW'(1);
        end
    end

    assign o_inv_busy  = inv_busy_ff;
    assign o_inv_valid = inv_busy_ff;
    assign o_inv_index = inv_idx_ff;

    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    a_rp_cut_mode: assert property (
        (i_rp_wr && !i_power_down_req && mode_ff != MODE_OFF)
        |=> (mode_ff == (rp_ff ? MODE_REDUCED : MODE_NORMAL)))
        else $error("reduced power write did not set the mode");

    a_pipe_norm_mult: assert property (
        (mode_ff == MODE_NORMAL) |-> (pipe_half == PIPE_HALF_TAB[sel_ff]))
        else $error("normal pipeline period does not follow ratio select");

    a_iface_norm_rate: assert property (
        (mode_ff == MODE_NORMAL)
        |-> (iface_half == (ifr_ff ? HALF_REF : half_t'(pipe_half * 2))))
        else $error("normal interface period wrong");

    a_pipe_quarter: assert property (
        (mode_ff == MODE_REDUCED) |-> (pipe_half == half_t'(pipe_norm * 4)))
        else $error("reduced pipeline period is not four times normal");

    a_iface_quarter: assert property (
        (mode_ff == MODE_REDUCED) |-> (iface_half == half_t'(iface_norm * 4)))
        else $error("reduced interface period is not four times normal");

    a_read_drained: assert property (
        (read_pend_ff && !i_wbuf_empty && !i_uncached_read_req)
        |=> !o_uncached_read_done ##0 read_pend_ff)
        else $error("uncached read completed with stores outstanding");

    a_ll_cleared: assert property (
        (i_inv_all_start && !i_ll_set) |=> !ll_ff)
        else $error("invalidation left the reservation flag set");

    a_sweep_end: assert property (
        (inv_busy_ff && inv_idx_ff == INV_LAST) |=> !inv_busy_ff)
        else $error("sweep did not end after the last entry");

    a_sweep_step: assert property (
        (inv_busy_ff && inv_idx_ff != INV_LAST)
        |=> (inv_busy_ff && inv_idx_ff == $past(inv_idx_ff) + IW'(1)))
        else $error("sweep skipped an entry");

    a_off_parked: assert property (
        (mode_ff == MODE_OFF && !o_pipeline_clock && !i_power_up_req)
        |=> !o_pipeline_clock [*2])
        else $error("pipeline clock ran in power off");

    a_rp_readback: assert property (
        i_rp_wr |=> (o_reduced_power_select == $past(i_rp_wdata)))
        else $error("reduced power bit readback differs from write");

    a_down_enters_off: assert property (
        i_power_down_req |=> (mode_ff == MODE_OFF))
        else $error("power down request did not reach power off");

    a_up_leaves_off: assert property (
        (mode_ff == MODE_OFF && i_power_up_req && !i_power_down_req && !i_rp_wr)
        |=> (mode_ff == MODE_NORMAL && !rp_ff))
        else $error("power up did not return to normal with the bit clear");

    a_ll_set_wins: assert property (
        i_ll_set |=> ll_ff)
        else $error("load-link did not set the reservation flag");

    a_read_done_once: assert property (
        (read_pend_ff && i_wbuf_empty && !i_uncached_read_req)
        |=> (o_uncached_read_done && !read_pend_ff))
        else $error("drained uncached read did not complete once");

    a_sel_settled: assert property (
        (sel_s2_ff != sel_s3_ff) |=> $stable(sel_ff))
        else $error("ratio select taken before its stages agreed");

    a_ifr_settled: assert property (
        (ifr_s2_ff != ifr_s3_ff) |=> $stable(ifr_ff))
        else $error("interface rate pin taken before its stages agreed");

    c_enter_reduced: cover property ($rose(mode_ff == MODE_REDUCED));
    c_enter_off:     cover property ($rose(mode_ff == MODE_OFF));
    c_sweep_done:    cover property ($fell(inv_busy_ff));
    c_read_waited:   cover property (read_pend_ff && !i_wbuf_empty ##[1:300] o_uncached_read_done);

endmodule

// [testbench/wbuf_model.sv]
// Write buffer behind the system interface, as the far side sees it.
// Assumes stores arrive as one-cycle pulses on the base clock.
`timescale 1ns/1ps
module wbuf_model #(
    parameter int unsigned DRAIN = 10
) (
    input  wire logic i_clock,     // Base clock
    input  wire logic i_rst,       // Async reset, active high
    input  wire logic i_store,     // Store enters buffer
    output logic      o_wbuf_empty // High when drained
);
    logic [3:0] count_ff;
    logic [7:0] tick_ff;

    // Entries leave slowly, one per drain
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_ff <= 4'h0;
            tick_ff  <= 8'h00;
        end else if (i_store) begin
            count_ff <= count_ff + 4'h1;
            tick_ff  <= 8'h00;
        end else if (count_ff != 4'h0) begin
            if (tick_ff == 8'(DRAIN - 1)) begin
                count_ff <= count_ff - 4'h1;
                tick_ff  <= 8'h00;
            end else begin
                tick_ff <= tick_ff + 8'h01;
            end
        end
    end

    assign o_wbuf_empty = (count_ff == 4'h0);
endmodule

// [testbench/tb_power_mode_clock_scaler.sv]
// Self-checking bench for the power mode clock scaler.
// Assumes a 50 MHz base clock and the write buffer model on the far side.
`timescale 1ns/1ps
module tb_power_mode_clock_scaler;
    import pm_pkg::*;
    logic i_clock = 1'b0, i_rst = 1'b1, i_iface_at_ref = 1'b0, i_rp_wr = 1'b0, i_rp_wdata = 1'b0;
    logic i_power_down_req = 1'b0, i_power_up_req = 1'b0, i_uncached_read_req = 1'b0;
    logic i_ll_set = 1'b0, i_ll_wr = 1'b0, i_ll_wdata = 1'b0, i_inv_all_start = 1'b0;
    logic store = 1'b0, wbuf_empty, o_reduced_power_select, o_uncached_read_done;
    logic o_link_reservation_flag, o_inv_busy, o_inv_valid, o_pipeline_clock, o_interface_clock;
    logic [1:0] i_clock_ratio_select = 2'h0;
    logic [5:0] o_inv_index;
    mode_t      o_mode;
    int         fail_count = 0;
    int         samples_checked = 0;

    always #10 i_clock = ~i_clock;

    power_mode_clock_scaler u_power_mode_clock_scaler (
        .i_clock(i_clock), .i_rst(i_rst), .i_clock_ratio_select(i_clock_ratio_select),
        .i_iface_at_ref(i_iface_at_ref), .i_rp_wr(i_rp_wr), .i_rp_wdata(i_rp_wdata),
        .o_reduced_power_select(o_reduced_power_select), .i_power_down_req(i_power_down_req),
        .i_power_up_req(i_power_up_req), .o_mode(o_mode),
        .i_uncached_read_req(i_uncached_read_req), .i_wbuf_empty(wbuf_empty),
        .o_uncached_read_done(o_uncached_read_done), .i_ll_set(i_ll_set), .i_ll_wr(i_ll_wr),
        .i_ll_wdata(i_ll_wdata), .o_link_reservation_flag(o_link_reservation_flag),
        .i_inv_all_start(i_inv_all_start), .o_inv_busy(o_inv_busy), .o_inv_valid(o_inv_valid),
        .o_inv_index(o_inv_index), .o_pipeline_clock(o_pipeline_clock),
        .o_interface_clock(o_interface_clock)
    );

    wbuf_model u_wbuf_model (
        .i_clock(i_clock), .i_rst(i_rst), .i_store(store), .o_wbuf_empty(wbuf_empty)
    );

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // One-cycle request pulse: 0 rp, 1 down, 2 up, 3 read, 4 ll set, 5 ll write, 6 sweep, 7 store
    task automatic pulse(input int k, input logic v);
        @(posedge i_clock);
        case (k)
            0: begin i_rp_wr <= 1'b1; i_rp_wdata <= v; end
            1: i_power_down_req <= 1'b1;
            2: i_power_up_req <= 1'b1;
            3: i_uncached_read_req <= 1'b1;
            4: i_ll_set <= 1'b1;
            5: begin i_ll_wr <= 1'b1; i_ll_wdata <= v; end
            6: i_inv_all_start <= 1'b1;
            default: store <= 1'b1;
        endcase
        @(posedge i_clock);
        {i_rp_wr, i_power_down_req, i_power_up_req, i_uncached_read_req} <= 4'h0;
        {i_ll_set, i_ll_wr, i_inv_all_start, store} <= 4'h0;
    endtask

    task automatic step();
        @(posedge i_clock);
        #1;
    endtask

    function automatic logic clk_of(input bit f);
        return f ? o_interface_clock : o_pipeline_clock;
    endfunction

    task automatic wait_lvl(input bit f, input logic v);
        int k;
        k = 0;
        while (clk_of(f) !== v && k < 600) begin
            step();
            k++;
        end
        if (k >= 600) begin
            fail_count++;
            test_done();
        end
    endtask

    // Two rises first so the new half period has been latched
    task automatic measure(input bit f, output int n);
        wait_lvl(f, 1'b0);
        wait_lvl(f, 1'b1);
        wait_lvl(f, 1'b0);
        wait_lvl(f, 1'b1);
        n = 0;
        while (clk_of(f) === 1'b1 && n < 600) begin
            step();
            n++;
        end
    endtask

    task automatic ratio_scan();
        int n, sh, ph;
        for (int s = 0; s < 4; s++) begin
            for (int a = 0; a < 2; a++) begin
                for (int r = 0; r < 2; r++) begin
                    @(posedge i_clock);
                    i_clock_ratio_select <= s[1:0];
                    i_iface_at_ref       <= a[0];
                    pulse(0, r[0]);
                    step();
                    check("mode", o_mode, r ? MODE_REDUCED : MODE_NORMAL);
                    check("rp_bit", o_reduced_power_select, r);
                    // Quiet for eight cycles after the mode write
                    repeat (8) step();
                    sh = r ? RP_SHIFT : 0;
                    ph = int'(PIPE_HALF_TAB[s]);
                    measure(1'b0, n);
                    check("pipe_half", n, ph << sh);
                    measure(1'b1, n);
                    check("iface_half", n, (a ? int'(HALF_REF) : 2 * ph) << sh);
                end
            end
        end
    endtask

    task automatic uncached_read();
        int k;
        pulse(3, 1'b0);
        #1;
        check("rd_early", o_uncached_read_done, 1'b0);
        step();
        check("rd_prompt", o_uncached_read_done, 1'b1);
        repeat (3) pulse(7, 1'b0);
        pulse(3, 1'b0);
        k = 0;
        while (o_uncached_read_done !== 1'b1 && k < 200) begin
            step();
            k++;
        end
        if (k >= 200) begin
            fail_count++;
            test_done();
        end
        check("rd_drained", wbuf_empty, 1'b1);
        check("rd_waited", k > 5, 1'b1);
        step();
        check("rd_single", o_uncached_read_done, 1'b0);
        // Drain model counts base cycles, so no agent needs retuning
        pulse(0, 1'b1);
        step();
        check("rp_after_rd", o_mode, MODE_REDUCED);
    endtask

    // system logic walks the modes down to off and back
    task automatic power_cycle();
        logic rp_save;
        pulse(0, 1'b1);
        pulse(4, 1'b0);
        step();
        // Restart state read out before power removal
        rp_save = o_reduced_power_select;
        pulse(1, 1'b0);
        step();
        check("mode_off", o_mode, MODE_OFF);
        pulse(0, 1'b1);
        step();
        check("off_held", o_mode, MODE_OFF);
        repeat (200) step();
        for (int i = 0; i < 20; i++) begin
            check("off_clk", {o_pipeline_clock, o_interface_clock}, 2'h0);
            step();
        end
        pulse(2, 1'b0);
        step();
        check("mode_up", o_mode, MODE_NORMAL);
        check("rp_up", o_reduced_power_select, 1'b0);
        // Cache invalidated on the way up, which drops the flag
        pulse(6, 1'b0);
        #1;
        check("ll_up", o_link_reservation_flag, 1'b0);
        repeat (66) step();
        check("inv_up_end", o_inv_busy, 1'b0);
        // Saved state written back after power-up
        pulse(0, rp_save);
        step();
        check("rp_restore", o_reduced_power_select, 1'b1);
        check("mode_restore", o_mode, MODE_REDUCED);
    endtask

    task automatic flag_and_sweep();
        pulse(5, 1'b1);
        step();
        check("ll_restore", o_link_reservation_flag, 1'b1);
        pulse(5, 1'b0);
        step();
        check("ll_clear", o_link_reservation_flag, 1'b0);
        pulse(4, 1'b0);
        pulse(6, 1'b0);
        #1;
        check("ll_swept", o_link_reservation_flag, 1'b0);
        for (int i = 0; i < 64; i++) begin
            check("inv_idx", {o_inv_busy, o_inv_valid, o_inv_index}, {2'h3, 6'(i)});
            step();
        end
        check("inv_end", o_inv_busy, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge i_clock);
        #1;
        check("rst_mode", o_mode, MODE_NORMAL);
        check("rst_clk", {o_pipeline_clock, o_interface_clock}, 2'h0);
        @(posedge i_clock);
        i_rst <= 1'b0;
        ratio_scan();
        pulse(0, 1'b0);
        uncached_read();
        power_cycle();
        flag_and_sweep();
        test_done();
    end
endmodule
